// >>> hw/ies_params.svh
// constants for the incremental encoder speed block
`ifndef IES_PARAMS_SVH
`define IES_PARAMS_SVH
`define IES_CLK_MHZ 25
`define IES_GATE_US 100000
`define IES_GATE_CYCLES (`IES_GATE_US * `IES_CLK_MHZ)
`define IES_RPM_FACTOR (60000000 / `IES_GATE_US)
`define IES_PCT_SCALE 40'h3E8
`define IES_CH_SEL_BIT 5
`define IES_OFF_CFG 3'h0
`define IES_OFF_LINES 3'h1
`define IES_OFF_FS_RPM 3'h2
`define IES_OFF_RAW_RPM 3'h3
`define IES_OFF_FILT_RPM 3'h4
`define IES_OFF_PCT 3'h5
`define IES_OFF_POS 3'h6
`define IES_CFG_MODE_BIT 0
`define IES_CFG_INV_BIT 1
`define IES_CFG_FT_LSB 4
`define IES_CFG_FT_MSB 7
`define IES_MODE_RST 1'h1
`define IES_LINES_RST 13'h3E8
`define IES_FS_RPM_RST 13'h3E8
`define IES_DIV_STEPS 6'h28
`endif

// >>> hw/ies_pkg.sv
// types for the incremental encoder speed block
package ies_pkg;
  typedef enum logic [0:0] {IES_PULSE_DIR = 1'b0, IES_QUAD = 1'b1} ies_mode_t;
  typedef enum logic [1:0] {SQ_IDLE = 2'b00, SQ_LOAD = 2'b01, SQ_WAIT = 2'b10} ies_seq_t;
endpackage

// >>> hw/ies_div.sv
// sequential unsigned divider, 40-bit numerator by 16-bit divisor
`timescale 1ns/100ps
`include "ies_params.svh"
module ies_div (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic start, // one-cycle start pulse
  input wire logic [39:0] num, // dividend, sampled at start
  input wire logic [15:0] den, // divisor, held while busy
  output logic done, // one-cycle pulse, quotient valid
  output logic [39:0] quo // quotient
);
  logic [16:0] rem_reg, rem_next;
  logic [39:0] quo_next;
  logic [5:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next, done_next;
  logic [16:0] trial;

  always_comb
  begin
    rem_next = rem_reg;
    quo_next = quo;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    trial = {rem_reg[15:0], quo[39]};
    if (start)
    begin
      rem_next = 17'h00000;
      quo_next = num;
      cnt_next = `IES_DIV_STEPS;
      busy_next = 1'b1;
    end
    else if (busy_reg)
    begin
      if (trial >= {1'b0, den})
      begin
        rem_next = trial - {1'b0, den};
        quo_next = {quo[38:0], 1'b1};
      end
      else
      begin
        rem_next = trial;
        quo_next = {quo[38:0], 1'b0};
      end
      cnt_next = cnt_reg - 6'h01;
      if (cnt_reg == 6'h01)
      begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rem_reg <= 17'h00000;
      quo <= 40'h0000000000;
      cnt_reg <= 6'h00;
      busy_reg <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      rem_reg <= rem_next;
      quo <= quo_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done <= done_next;
    end
  end
endmodule // ies_div

// >>> hw/ies_chan.sv
// one encoder channel: synchroniser, decoder, position and gate counters
`timescale 1ns/100ps
module ies_chan (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic pulse_or_a_input, // pulse or phase A pin, async
  input wire logic direction_or_b_input, // direction or phase B pin, async
  input wire logic quad_mode, // 1 quadrature, 0 pulse and direction
  input wire logic invert, // reverse count direction
  input wire logic gate_tick, // end of gate period
  output logic signed [31:0] position, // wrapping position count
  output logic signed [23:0] gate_count // counts in last gate period
);
  logic a_s1, a_s2, a_d, b_s1, b_s2, b_d;
  logic signed [31:0] position_next;
  logic signed [23:0] acc_reg, acc_next, gate_count_next;
  logic signed [2:0] step;
  logic [1:0] settle_reg, settle_next;

  function automatic logic signed [2:0] quad_step(input logic [3:0] tr);
    unique case (tr)
      4'h1, 4'h7, 4'hE, 4'h8: quad_step = 3'sd1;
      4'h2, 4'hB, 4'hD, 4'h4: quad_step = -3'sd1;
      default: quad_step = 3'sd0;
    endcase
  endfunction

  always_comb
  begin
    // no steps until the delay stage holds a real pin sample, so that a pin
    // idling high cannot look like an edge right after reset
    settle_next = settle_reg;
    step = 3'sd0;
    if (settle_reg != 2'h3)
      settle_next = settle_reg + 2'h1;
    else if (quad_mode)
      step = quad_step({a_d, b_d, a_s2, b_s2});
    else if (a_s2 && !a_d)
      step = b_s2 ? 3'sd1 : -3'sd1;
    if (invert)
      step = -step;
    position_next = position + 32'(step);
    acc_next = acc_reg + 24'(step);
    gate_count_next = gate_count;
    if (gate_tick)
    begin
      gate_count_next = acc_next;
      acc_next = 24'sh000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_s1 <= 1'b0;
      a_s2 <= 1'b0;
      a_d <= 1'b0;
      b_s1 <= 1'b0;
      b_s2 <= 1'b0;
      b_d <= 1'b0;
      settle_reg <= 2'h0;
      position <= 32'sh00000000;
      acc_reg <= 24'sh000000;
      gate_count <= 24'sh000000;
    end
    else
    begin
      a_s1 <= pulse_or_a_input;
      a_s2 <= a_s1;
      a_d <= a_s2;
      b_s1 <= direction_or_b_input;
      b_s2 <= b_s1;
      b_d <= b_s2;
      settle_reg <= settle_next;
      position <= position_next;
      acc_reg <= acc_next;
      gate_count <= gate_count_next;
    end
  end
endmodule // ies_chan

// >>> hw/ies_top.sv
// two-channel encoder speed block with APB register access
`timescale 1ns/100ps
`include "ies_params.svh"
// Notes on behaviour
// - two independent channels, each with own lines, sign, full-scale and mode
// - mode value 0 is pulse and direction, value 1 is quadrature
// - quadrature direction comes from combined state of phases A and B
// - quadrature counts on every edge of either phase, four per line
// - speed is count rate over lines, times four in quadrature, then filtered
// - channel two pulse input clocks the count, direction input sets sign
// - channel two quadrature uses first input as A, second as B
// - pulse mode counts up when direction high, down when low
// - one count per full pulse, taken at the rising edge
// - pulse and direction offered on channel two, and here on both
// - channel one pulse mode takes its clock from the A terminal
// - a sign setting inverts count direction and reported speed
// - line count defaults to 1000 per revolution
// - full-scale RPM setting is the top speed, one hundred percent
// - percent speed is linear, in tenths of a percent, exactly 1000 at full-scale RPM
// - both raw and filtered RPM are reported for each channel
module ies_top #(
  parameter int GATE_CYCLES = `IES_GATE_CYCLES // clocks per gate period
) (
  input wire logic pclk, // APB clock, 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, 1 write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic pulse_or_a_input_0, // channel 0 pulse or A pin
  input wire logic direction_or_b_input_0, // channel 0 direction or B pin
  input wire logic pulse_or_a_input_1, // channel 1 pulse or A pin
  input wire logic direction_or_b_input_1 // channel 1 direction or B pin
);
  // per-channel settings
  ies_pkg::ies_mode_t mode_reg [2];
  ies_pkg::ies_mode_t mode_next [2];
  logic invert_reg [2], invert_next [2];
  logic [3:0] ftime_reg [2], ftime_next [2];
  logic [12:0] lines_reg [2], lines_next [2];
  logic [12:0] fs_rpm_reg [2], fs_rpm_next [2];
  // per-channel results
  logic signed [31:0] raw_speed_rpm [2], raw_next [2];
  logic signed [31:0] filt_rpm_reg [2], filt_next [2];
  logic signed [31:0] pct_reg [2], pct_next [2];
  logic signed [31:0] position [2];
  logic signed [23:0] gate_count [2];
  // gate timer and sequencer
  logic [31:0] gate_cnt_reg, gate_cnt_next;
  logic gate_tick_reg, gate_tick_next;
  ies_pkg::ies_seq_t seq_reg, seq_next;
  logic [1:0] job_reg, job_next;
  logic div_start, div_done;
  logic [39:0] div_num, div_quo;
  logic [15:0] div_den;
  logic [15:0] den_hold_reg, den_hold_next;
  logic ch;
  logic signed [32:0] diff;
  logic signed [31:0] res;
  // bus
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic bus_ch, bus_hit, bus_wr;
  logic [2:0] bus_idx;

  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    mag32 = v[31] ? 32'(-v) : 32'(v);
  endfunction

  // the divider works on magnitudes; the sign is put back from count or filter
  function automatic logic signed [31:0] signed_of(input logic [39:0] q, input logic neg);
    signed_of = neg ? -$signed(q[31:0]) : $signed(q[31:0]);
  endfunction

  ies_chan u_ch0 (
    .pclk(pclk),
    .presetn(presetn),
    .pulse_or_a_input(pulse_or_a_input_0),
    .direction_or_b_input(direction_or_b_input_0),
    .quad_mode(mode_reg[0] == ies_pkg::IES_QUAD),
    .invert(invert_reg[0]),
    .gate_tick(gate_tick_reg),
    .position(position[0]),
    .gate_count(gate_count[0])
  );

  ies_chan u_ch1 (
    .pclk(pclk),
    .presetn(presetn),
    .pulse_or_a_input(pulse_or_a_input_1),
    .direction_or_b_input(direction_or_b_input_1),
    .quad_mode(mode_reg[1] == ies_pkg::IES_QUAD),
    .invert(invert_reg[1]),
    .gate_tick(gate_tick_reg),
    .position(position[1]),
    .gate_count(gate_count[1])
  );

  ies_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(div_start),
    .num(div_num),
    .den(den_hold_reg),
    .done(div_done),
    .quo(div_quo)
  );

  // gate timer: one tick every GATE_CYCLES clocks
  always_comb
  begin
    gate_cnt_next = gate_cnt_reg + 32'h00000001;
    gate_tick_next = 1'b0;
    if (gate_cnt_reg == 32'(GATE_CYCLES - 1))
    begin
      gate_cnt_next = 32'h00000000;
      gate_tick_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_cnt_reg <= 32'h00000000;
      gate_tick_reg <= 1'b0;
    end
    else
    begin
      gate_cnt_reg <= gate_cnt_next;
      gate_tick_reg <= gate_tick_next;
    end
  end

  // division sequencer: rpm then percent, channel 0 then 1
  always_comb
  begin
    ch = job_reg[1];
    seq_next = seq_reg;
    job_next = job_reg;
    div_start = (seq_reg == ies_pkg::SQ_LOAD);
    if (!job_reg[0])
    begin
      div_num = 40'(mag32(32'(gate_count[ch]))) * 40'(`IES_RPM_FACTOR);
      div_den = (mode_reg[ch] == ies_pkg::IES_QUAD) ? {1'b0, lines_reg[ch], 2'b00}
        : {3'b000, lines_reg[ch]};
    end
    else
    begin
      div_num = 40'(mag32(filt_rpm_reg[ch])) * `IES_PCT_SCALE;
      div_den = {3'b000, fs_rpm_reg[ch]};
    end
    // a bus write to the settings mid-division must not change the divisor
    den_hold_next = den_hold_reg;
    if (seq_reg == ies_pkg::SQ_LOAD)
      den_hold_next = div_den;
    raw_next = raw_speed_rpm;
    filt_next = filt_rpm_reg;
    pct_next = pct_reg;
    diff = 33'sh000000000;
    res = 32'sh00000000;
    unique case (seq_reg)
      ies_pkg::SQ_IDLE:
        if (gate_tick_reg)
        begin
          job_next = 2'b00;
          seq_next = ies_pkg::SQ_LOAD;
        end
      ies_pkg::SQ_LOAD:
        seq_next = ies_pkg::SQ_WAIT;
      ies_pkg::SQ_WAIT:
        if (div_done)
        begin
          if (!job_reg[0])
          begin
            res = (den_hold_reg == 16'h0000) ? 32'sh00000000
              : signed_of(div_quo, gate_count[ch][23]);
            raw_next[ch] = res;
            // first-order low pass: each gate moves by the error over two to the shift
            diff = 33'(res) - 33'(filt_rpm_reg[ch]);
            filt_next[ch] = filt_rpm_reg[ch] + 32'(diff >>> ftime_reg[ch]);
          end
          else
            pct_next[ch] = (den_hold_reg == 16'h0000) ? 32'sh00000000
              : signed_of(div_quo, filt_rpm_reg[ch][31]);
          job_next = job_reg + 2'b01;
          seq_next = (job_reg == 2'b11) ? ies_pkg::SQ_IDLE : ies_pkg::SQ_LOAD;
        end
      default:
        seq_next = ies_pkg::SQ_IDLE;
    endcase
  end

  // APB slave: one wait-free access phase, error on unmapped address
  always_comb
  begin
    bus_ch = paddr[`IES_CH_SEL_BIT];
    bus_idx = paddr[4:2];
    bus_hit = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00) && (bus_idx <= `IES_OFF_POS);
    bus_wr = psel && penable && pready && pwrite && bus_hit;
    pready_next = psel && !penable;
    pslverr_next = psel && !penable && !bus_hit;
    prdata_next = 32'h00000000;
    if (psel && !penable && !pwrite && bus_hit)
    begin
      unique case (bus_idx)
        `IES_OFF_CFG:
        begin
          prdata_next[`IES_CFG_MODE_BIT] = mode_reg[bus_ch];
          prdata_next[`IES_CFG_INV_BIT] = invert_reg[bus_ch];
          prdata_next[`IES_CFG_FT_MSB:`IES_CFG_FT_LSB] = ftime_reg[bus_ch];
        end
        `IES_OFF_LINES: prdata_next = {19'h00000, lines_reg[bus_ch]};
        `IES_OFF_FS_RPM: prdata_next = {19'h00000, fs_rpm_reg[bus_ch]};
        `IES_OFF_RAW_RPM: prdata_next = raw_speed_rpm[bus_ch];
        `IES_OFF_FILT_RPM: prdata_next = filt_rpm_reg[bus_ch];
        `IES_OFF_PCT: prdata_next = pct_reg[bus_ch];
        default: prdata_next = position[bus_ch];
      endcase
    end
    mode_next = mode_reg;
    invert_next = invert_reg;
    ftime_next = ftime_reg;
    lines_next = lines_reg;
    fs_rpm_next = fs_rpm_reg;
    if (bus_wr)
    begin
      if (bus_idx == `IES_OFF_CFG)
      begin
        mode_next[bus_ch] = ies_pkg::ies_mode_t'(pwdata[`IES_CFG_MODE_BIT]);
        invert_next[bus_ch] = pwdata[`IES_CFG_INV_BIT];
        ftime_next[bus_ch] = pwdata[`IES_CFG_FT_MSB:`IES_CFG_FT_LSB];
      end
      if (bus_idx == `IES_OFF_LINES)
        lines_next[bus_ch] = pwdata[12:0];
      if (bus_idx == `IES_OFF_FS_RPM)
        fs_rpm_next[bus_ch] = pwdata[12:0];
    end
  end

  // sequencer and speed results
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_reg <= ies_pkg::SQ_IDLE;
      job_reg <= 2'b00;
      den_hold_reg <= 16'h0000;
      for (int i = 0; i < 2; i++)
      begin
        raw_speed_rpm[i] <= 32'sh00000000;
        filt_rpm_reg[i] <= 32'sh00000000;
        pct_reg[i] <= 32'sh00000000;
      end
    end
    else
    begin
      seq_reg <= seq_next;
      job_reg <= job_next;
      den_hold_reg <= den_hold_next;
      raw_speed_rpm <= raw_next;
      filt_rpm_reg <= filt_next;
      pct_reg <= pct_next;
    end
  end

  // bus answer and settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        mode_reg[i] <= ies_pkg::ies_mode_t'(`IES_MODE_RST);
        invert_reg[i] <= 1'b0;
        ftime_reg[i] <= 4'h0;
        lines_reg[i] <= `IES_LINES_RST;
        fs_rpm_reg[i] <= `IES_FS_RPM_RST;
      end
    end
    else
    begin
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      mode_reg <= mode_next;
      invert_reg <= invert_next;
      ftime_reg <= ftime_next;
      lines_reg <= lines_next;
      fs_rpm_reg <= fs_rpm_next;
    end
  end
endmodule // ies_top

// >>> verification/ies_enc_model.sv
// shaft encoder model driving the two pins of one channel
`timescale 1ns/100ps
module ies_enc_model (
  input wire logic pclk, // pacing clock
  input wire logic run, // one step per eight clocks while high
  input wire logic fwd, // forward rotation
  input wire logic quad, // 1 quadrature phases, 0 pulse and direction
  output logic pin_a, // pulse or phase a
  output logic pin_b // direction or phase b
);
  logic [2:0] cnt_reg = 3'h0;
  logic [1:0] ph_reg = 2'h0;
  always @(posedge pclk)
  begin
    cnt_reg <= run ? cnt_reg + 3'h1 : 3'h0;
    if (run && quad && cnt_reg == 3'h7)
      ph_reg <= fwd ? ph_reg + 2'h1 : ph_reg - 2'h1;
  end
  // phases a quarter cycle apart, forward order 00 01 11 10
  assign pin_a = quad ? ph_reg[1] : run && !cnt_reg[2];
  assign pin_b = quad ? ph_reg[1] ^ ph_reg[0] : fwd;
endmodule // ies_enc_model

// >>> verification/ies_top_assertions.sv
// register bus checks for the encoder speed block
`timescale 1ns/100ps
module ies_top_assertions (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic pulse_or_a_input_0, // ch0 pin a
  input wire logic direction_or_b_input_0, // ch0 pin b
  input wire logic pulse_or_a_input_1, // ch1 pin a
  input wire logic direction_or_b_input_1 // ch1 pin b
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  high_addr_err_a: assert property (psel && !penable && paddr[11:6] != 6'h0 |=> pslverr)
    else $error("high address accepted");
  align_err_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned address accepted");
  index_err_a: assert property (psel && !penable && paddr[4:2] == 3'h7 |=> pslverr)
    else $error("index seven accepted");
  mapped_ok_a: assert property (psel && !penable && paddr[11:6] == 6'h0 && paddr[1:0] == 2'h0
    && paddr[4:2] != 3'h7 |=> !pslverr)
    else $error("mapped address refused");
endmodule // ies_top_assertions
bind ies_top ies_top_assertions ies_top_assertions_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_or_a_input_0(pulse_or_a_input_0),
  .direction_or_b_input_0(direction_or_b_input_0), .pulse_or_a_input_1(pulse_or_a_input_1),
  .direction_or_b_input_1(direction_or_b_input_1));

// >>> verification/ies_top_test.sv
// self-checking bench for the encoder speed block
`timescale 1ns/100ps
module ies_top_test;
  localparam int GATE = 1000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] run = 2'h0;
  logic [1:0] fwd = 2'h3;
  logic [1:0] quad = 2'h3;
  logic [1:0] pa;
  logic [1:0] pb;
  logic [31:0] rdv;
  logic errv;
  int error_cnt = 0;
  int comparisons = 0;
  always #20 pclk = ~pclk;
  ies_top #(.GATE_CYCLES(GATE)) ies_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_or_a_input_0(pa[0]),
    .direction_or_b_input_0(pb[0]), .pulse_or_a_input_1(pa[1]), .direction_or_b_input_1(pb[1]));
  ies_enc_model ies_enc_model_inst [1:0] (.pclk(pclk), .run(run), .fwd(fwd), .quad(quad),
    .pin_a(pa), .pin_b(pb));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [32:0] x, input logic [32:0] g);
    comparisons++;
    if (g !== x)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", w, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge pclk);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16)
    begin
      chk("pready", 33'h1, 33'h0);
      summarize();
    end
  endtask
  task automatic rd(input string w, input logic [11:0] a, input logic [31:0] x, input logic e);
    apb(1'b0, a, 32'h0);
    chk(w, {e, x}, {errv, rdv});
  endtask
  task automatic wr(input string w, input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk(w, 33'(e), 33'(errv));
  endtask
  // step one channel n times, expect position to move by dx
  task automatic ps(input int c, input logic d, input int n, input logic [31:0] dx);
    logic [31:0] p0;
    apb(1'b0, 12'(c * 32 + 24), 32'h0);
    p0 = rdv;
    fwd[c] <= d;
    repeat (4) @(posedge pclk);
    run[c] <= 1'b1;
    repeat (8 * n) @(posedge pclk);
    run[c] <= 1'b0;
    repeat (12) @(posedge pclk);
    rd("pos", 12'(c * 32 + 24), p0 + dx, 1'b0);
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 2; c++)
    begin
      rd("cfg", 12'(c * 32), 32'h1, 1'b0);
      rd("lines", 12'(c * 32 + 4), 32'h3E8, 1'b0);
      rd("fs_rpm", 12'(c * 32 + 8), 32'h3E8, 1'b0);
      rd("raw", 12'(c * 32 + 12), 32'h0, 1'b0);
      rd("pos", 12'(c * 32 + 24), 32'h0, 1'b0);
    end
    $display("test reset values done");
    rd("idx7", 12'h01C, 32'h0, 1'b1);
    rd("unaligned", 12'h006, 32'h0, 1'b1);
    wr("wr unmapped", 12'h044, 32'h5, 1'b1);
    rd("lines kept", 12'h004, 32'h3E8, 1'b1 ^ 1'b1);
    wr("wr pos", 12'h018, 32'h5A, 1'b0);
    rd("pos ro", 12'h018, 32'h0, 1'b0);
    $display("test map done");
    ps(0, 1'b1, 8, 32'h8);
    ps(0, 1'b0, 3, 32'hFFFF_FFFD);
    ps(1, 1'b1, 4, 32'h4);
    apb(1'b1, 12'h000, 32'h3);
    ps(0, 1'b1, 2, 32'hFFFF_FFFE);
    $display("test quadrature done");
    for (int c = 0; c < 2; c++)
    begin
      quad[c] <= 1'b0;
      apb(1'b1, 12'(c * 32), 32'h0);
      ps(c, 1'b1, 3, 32'h3);
      ps(c, 1'b0, 2, 32'hFFFF_FFFE);
    end
    $display("test pulse mode done");
    quad <= 2'b01;
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h004, 32'hA);
    apb(1'b1, 12'h008, 32'h753);
    apb(1'b1, 12'h024, 32'hA);
    fwd <= 2'h3;
    run <= 2'h3;
    repeat (3 * GATE) @(posedge pclk);
    rd("raw0", 12'h00C, 32'h753, 1'b0);
    rd("filt0", 12'h010, 32'h753, 1'b0);
    rd("pct0", 12'h014, 32'h3E8, 1'b0);
    rd("raw1", 12'h02C, 32'h1D4C, 1'b0);
    rd("pct1", 12'h034, 32'h1D4C, 1'b0);
    apb(1'b1, 12'h000, 32'h3);
    repeat (3 * GATE) @(posedge pclk);
    rd("raw0 inv", 12'h00C, 32'hFFFF_F8AD, 1'b0);
    rd("pct0 inv", 12'h014, 32'hFFFF_FC18, 1'b0);
    run <= 2'h0;
    $display("test speed done");
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("cfg0 rst", 12'h000, 32'h1, 1'b0);
    rd("pos0 rst", 12'h018, 32'h0, 1'b0);
    wr("cfg1 ft", 12'h020, 32'hF0, 1'b0);
    wr("lines1", 12'h024, 32'hA, 1'b0);
    run <= 2'h2;
    repeat (3 * GATE) @(posedge pclk);
    rd("raw1 ft", 12'h02C, 32'h1D4C, 1'b0);
    rd("filt1 ft", 12'h030, 32'h0, 1'b0);
    run <= 2'h0;
    $display("test filter done");
    summarize();
  end
endmodule // ies_top_test
